// [design/tpwm_pkg.sv]
// shared constants, register map and bus carriers of the timer pwm unit
package tpwm_pkg;

	localparam int TPWM_NCH_DEF = 2;
	localparam int TPWM_AW = 8;

	// register byte addresses
	localparam logic [7:0] TPWM_CTRL_OFS = 8'h00;
	localparam logic [7:0] TPWM_COUNT_OFS = 8'h04;
	localparam logic [7:0] TPWM_MOD_OFS = 8'h08;
	localparam logic [7:0] TPWM_CH_BASE_OFS = 8'h10;

	// control register fields; the direction bit sits in the count register
	localparam int TPWM_CLKS_LSB = 0;
	localparam int TPWM_PS_LSB = 2;
	localparam int TPWM_CENTER_BIT = 5;
	localparam int TPWM_DIR_BIT = 16;

	// values after reset
	localparam logic [1:0] TPWM_CLKS_RST = 2'h0;
	localparam logic [2:0] TPWM_PS_RST = 3'h0;
	localparam logic TPWM_CENTER_RST = 1'b0;
	localparam logic [15:0] TPWM_COUNT_RST = 16'h0000;
	localparam logic [15:0] TPWM_MOD_RST = 16'h0000;
	localparam logic [15:0] TPWM_CH_RST = 16'h0000;
	localparam logic [6:0] TPWM_PRESC_RST = 7'h00;

	localparam logic [1:0] TPWM_RESP_OKAY = 2'h0;
	localparam logic [1:0] TPWM_RESP_DECERR = 2'h3;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tpwm_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpwm_axi_rsp_t;

	// byte-wise update of a 16-bit value: lane 0 low byte, lane 1 high byte
	function automatic logic [15:0] tpwm_merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// last prescaler state before a counter tick, divide by 2^ps
	function automatic logic [6:0] tpwm_presc_last(input logic [2:0] ps);
		logic [7:0] full;
		full = (8'h01 << ps) - 8'h01;
		return full[6:0];
	endfunction

endpackage

// [design/tpwm_top.sv]
// timer pwm unit: 16-bit up/down counter, per-channel pwm, axi4-lite registers
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - center mode counts up to modulo, down to zero; period is twice modulo
// - each output is a flip-flop, reset low, changed only on a counter tick
// - reset clears the 16-bit count to zero, mid-period for center mode
// - center mode: channel value equal to modulo holds output active, 100 percent
// - negative channel values give 0 percent duty, output held inactive
// - center mode: value modulo minus one gives value over modulo duty, never zero
// - down-counting is the first half of the period, up-counting the second
// - center mode: a new channel value waits for the next period start
// - changing to zero in the second half finishes that period with the old value
// - center mode: zero, nonzero, zero: first period inactive, next active twice the value
// - edge mode: zero to nonzero takes effect after one extra 0 percent period
// - clock source select zero stops the counter; nonzero restarts it
// - writing either count byte clears the count to zero
// - three-bit prescale field picks divide factor; 001 divides by two
// - prescale changed only with clocks off; divider restarts from zero; a control write updates ps even while counting
// - up-count reaching modulo turns to down-count on the next counter edge
// - clearing the count also clears direction so counting restarts upward
module tpwm_top import tpwm_pkg::*; #(
	parameter int NCH = TPWM_NCH_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire tpwm_axi_req_t axi_req,
	output tpwm_axi_rsp_t axi_rsp,
	output logic [NCH-1:0] pwm_out
);

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		tpwm_axi_rsp_t rsp;
		logic [1:0] clks;
		logic [2:0] ps;
		logic center;
		logic [6:0] presc;
		logic [15:0] cnt;
		logic down;
		logic [15:0] modv;
		logic [NCH-1:0][15:0] ch_buf;
		logic [NCH-1:0][15:0] ch_act;
		logic [NCH-1:0] hold;
		logic [NCH-1:0] pwm;
	} tpwm_state_t;

	tpwm_state_t q;
	tpwm_state_t d;
	logic wr_go;
	logic cnt_wr;
	logic run;
	logic tick;
	logic boundary;
	logic [15:0] nxt;
	logic ndown;

	assign axi_rsp = q.rsp;
	assign pwm_out = q.pwm;

	function automatic tpwm_state_t reset_state();
		tpwm_state_t s;
		s = '0;
		s.clks = TPWM_CLKS_RST;
		s.ps = TPWM_PS_RST;
		s.center = TPWM_CENTER_RST;
		s.presc = TPWM_PRESC_RST;
		s.cnt = TPWM_COUNT_RST;
		s.modv = TPWM_MOD_RST;
		for (int i = 0; i < NCH; i++) begin
			s.ch_buf[i] = TPWM_CH_RST;
			s.ch_act[i] = TPWM_CH_RST;
		end
		return s;
	endfunction

	// channel index from a byte address; valid flag in bit 8
	function automatic logic [8:0] ch_decode(input logic [7:0] a);
		logic [8:0] r;
		r = '0;
		for (int i = 0; i < NCH; i++) begin
			if (a == 8'(TPWM_CH_BASE_OFS + 8'(i * 4))) begin
				r = {1'b1, 8'(i)};
			end
		end
		return r;
	endfunction

	// read mux; bit 32 flags a mapped address
	function automatic logic [32:0] read_word(input tpwm_state_t s, input logic [7:0] a);
		logic [32:0] r;
		logic [8:0] ci;
		r = '0;
		ci = ch_decode(a);
		if (a == TPWM_CTRL_OFS) begin
			r[32] = 1'b1;
			r[TPWM_CLKS_LSB +: 2] = s.clks;
			r[TPWM_PS_LSB +: 3] = s.ps;
			r[TPWM_CENTER_BIT] = s.center;
		end else if (a == TPWM_COUNT_OFS) begin
			r[32] = 1'b1;
			r[15:0] = s.cnt;
			r[TPWM_DIR_BIT] = s.down;
		end else if (a == TPWM_MOD_OFS) begin
			r[32] = 1'b1;
			r[15:0] = s.modv;
		end else if (ci[8]) begin
			r[32] = 1'b1;
			r[15:0] = s.ch_buf[ci[7:0]];
		end
		return r;
	endfunction

	always_comb begin
		logic [32:0] rd;
		logic [8:0] ci;
		logic [15:0] na;
		rd = '0;
		ci = '0;
		na = '0;
		d = q;
		cnt_wr = 1'b0;
		wr_go = q.aw_have && q.w_have && !q.rsp.bvalid;

		// write address and data are taken independently, in either order
		if (axi_req.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.w_data = axi_req.wdata;
			d.w_strb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = TPWM_RESP_OKAY;
			ci = ch_decode(q.aw_addr);
			if (q.aw_addr == TPWM_CTRL_OFS) begin
				if (q.w_strb[0]) begin
					d.clks = q.w_data[TPWM_CLKS_LSB +: 2];
					d.ps = q.w_data[TPWM_PS_LSB +: 3];
					d.center = q.w_data[TPWM_CENTER_BIT];
				end
			end else if (q.aw_addr == TPWM_COUNT_OFS) begin
				cnt_wr = |q.w_strb[1:0];
			end else if (q.aw_addr == TPWM_MOD_OFS) begin
				d.modv = tpwm_merge16(q.modv, q.w_data, q.w_strb);
			end else if (ci[8]) begin
				d.ch_buf[ci[7:0]] = tpwm_merge16(q.ch_buf[ci[7:0]], q.w_data, q.w_strb);
			end else begin
				d.rsp.bresp = TPWM_RESP_DECERR;
			end
		end

		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && q.rsp.arready) begin
			rd = read_word(q, axi_req.araddr);
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata = rd[31:0];
			d.rsp.rresp = rd[32] ? TPWM_RESP_OKAY : TPWM_RESP_DECERR;
		end
		d.rsp.awready = !d.aw_have;
		d.rsp.wready = !d.w_have;
		d.rsp.arready = !d.rsp.rvalid;

		// prescaler held at zero while stopped, so a restart begins a fresh divide
		run = q.clks != 2'h0;
		tick = run && (q.presc == tpwm_presc_last(q.ps));
		if (!run || tick) begin
			d.presc = TPWM_PRESC_RST;
		end else begin
			d.presc = q.presc + 7'h01;
		end

		// next count and direction
		nxt = q.cnt;
		ndown = q.down;
		if (q.center) begin
			if (q.modv == 16'h0000) begin
				nxt = 16'h0000;
				ndown = 1'b0;
			end else if (!q.down) begin
				if (q.cnt >= q.modv) begin
					ndown = 1'b1;
					nxt = q.cnt - 16'h0001;
				end else begin
					nxt = q.cnt + 16'h0001;
				end
			end else if (q.cnt == 16'h0000) begin
				ndown = 1'b0;
				nxt = 16'h0001;
			end else begin
				nxt = q.cnt - 16'h0001;
			end
		end else begin
			ndown = 1'b0;
			nxt = (q.cnt >= q.modv) ? 16'h0000 : q.cnt + 16'h0001;
		end
		// center period starts where up-counting reaches modulo
		boundary = tick && (q.center ? (!q.down && nxt == q.modv) : (nxt == 16'h0000));
		if (tick) begin
			d.cnt = nxt;
			d.down = ndown;
		end
		if (cnt_wr) begin
			d.cnt = TPWM_COUNT_RST;
			d.down = 1'b0;
		end

		for (int i = 0; i < NCH; i++) begin
			na = q.ch_act[i];
			if (boundary) begin
				// edge mode inserts one idle period when leaving zero
				if (!q.center && q.ch_act[i] == 16'h0000 && q.ch_buf[i] != 16'h0000 && !q.hold[i]) begin
					d.hold[i] = 1'b1;
				end else begin
					na = q.ch_buf[i];
					d.hold[i] = 1'b0;
				end
				d.ch_act[i] = na;
			end
			// a count change while counting is the only compare event
			if (tick) begin
				if (na[15] || na == 16'h0000) begin
					d.pwm[i] = 1'b0;
				end else if (q.center) begin
					if (na >= q.modv) begin
						d.pwm[i] = 1'b1;
					end else if (nxt == na) begin
						d.pwm[i] = ndown;
					end
				end else if (nxt == 16'h0000) begin
					d.pwm[i] = 1'b1;
				end else if (nxt == na) begin
					d.pwm[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= reset_state();
		end else begin
			q <= d;
		end
	end

	reset_count_a: assert property (@(posedge aclk) !aresetn |=> q.cnt == 16'h0000 && q.pwm == '0)
		else $error("count or output not cleared by reset");

	stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.clks == 2'h0 && !cnt_wr) |=> $stable(q.cnt))
		else $error("count moved while stopped");

	count_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_wr |=> (q.cnt == 16'h0000 && !q.down))
		else $error("count write did not clear count and direction");

	turn_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && !q.down && q.modv != 16'h0000 && q.cnt == q.modv && !cnt_wr)
		|=> (q.down && q.cnt == $past(q.modv) - 16'h0001))
		else $error("no turn to down-count at modulo");

	bottom_turn_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && q.down && q.cnt == 16'h0000 && !cnt_wr) |=> (!q.down && q.cnt == 16'h0001))
		else $error("no turn to up-count at zero");

	presc_rest_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.clks == 2'h0) |=> (q.presc == 7'h00))
		else $error("prescaler not held at zero while stopped");

	div_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.ps == 3'h1 && q.clks != 2'h0 && q.presc == 7'h00 && $stable(q.ps) && !wr_go) |=> tick)
		else $error("divide by two did not tick on second cycle");

	full_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && !boundary && !q.ch_act[0][15] && q.ch_act[0] != 16'h0000
		&& q.ch_act[0] >= q.modv) |=> q.pwm[0])
		else $error("full duty channel went inactive");

	neg_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && !boundary && q.ch_act[0][15]) |=> !q.pwm[0])
		else $error("negative channel value drove output active");

	act_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!boundary |=> $stable(q.ch_act))
		else $error("channel value took effect mid-period");

	out_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!tick |=> $stable(q.pwm))
		else $error("output changed without a counter event");

	// channel 0 stands for all channels in the checks below
	period_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && !q.down && q.modv != 16'h0000 && q.cnt == q.modv - 16'h0001) |-> boundary)
		else $error("center period did not start at the turn to modulo");

	edge_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && !q.center && q.cnt >= q.modv) |-> boundary)
		else $error("edge period did not start at the wrap");

	center_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(boundary && q.center) |=> q.ch_act[0] == $past(q.ch_buf[0]))
		else $error("buffered channel value not applied at period start");

	idle_insert_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(boundary && !q.center && q.ch_act[0] == 16'h0000 && q.ch_buf[0] != 16'h0000 && !q.hold[0])
		|=> (q.hold[0] && q.ch_act[0] == 16'h0000))
		else $error("edge mode skipped the idle period on leaving zero");

	idle_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(boundary && !q.center && q.hold[0]) |=> (!q.hold[0] && q.ch_act[0] == $past(q.ch_buf[0])))
		else $error("edge mode held the idle period too long");

	edge_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(boundary && !q.center && q.ch_act[0] != 16'h0000 && q.ch_buf[0] != 16'h0000 && !q.ch_buf[0][15])
		|=> q.pwm[0])
		else $error("edge mode output not raised at period start");

	zero_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && !boundary && q.ch_act[0] == 16'h0000) |=> !q.pwm[0])
		else $error("zero channel value drove output active");

	match_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && !boundary && q.down && q.ch_act[0] != 16'h0000 && !q.ch_act[0][15]
		&& q.ch_act[0] < q.modv && q.cnt == q.ch_act[0] + 16'h0001) |=> q.pwm[0])
		else $error("output not raised at the down-count match");

	match_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && q.center && !boundary && !q.down && q.ch_act[0] != 16'h0000 && !q.ch_act[0][15]
		&& q.ch_act[0] < q.modv && q.cnt == q.ch_act[0] - 16'h0001) |=> !q.pwm[0])
		else $error("output not lowered at the up-count match");

endmodule

// [testbench/tpwm_sw_model.sv]
// software side: axi4-lite master plus duty word precautions
`timescale 1ns/1ps
module tpwm_sw_model import tpwm_pkg::*; (
	input wire logic aclk,
	input wire tpwm_axi_rsp_t axi_rsp,
	output tpwm_axi_req_t axi_req
);
	initial begin
		axi_req = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw;
		logic wd;
		aw = 1'b1;
		wd = 1'b1;
		@(posedge aclk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= s;
		axi_req.bready <= 1'b1;
		while (aw || wd) begin
			@(posedge aclk);
			aw = aw && !axi_rsp.awready;
			wd = wd && !axi_rsp.wready;
			axi_req.awvalid <= aw;
			axi_req.wvalid <= wd;
		end
		while (!axi_rsp.bvalid) begin
			@(posedge aclk);
		end
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		axi_req.rready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (!axi_rsp.arready);
		axi_req.arvalid <= 1'b0;
		while (!axi_rsp.rvalid) begin
			@(posedge aclk);
		end
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
	// keeps channel words off the zero and modulo corners
	function automatic logic [15:0] duty_word(input logic [15:0] v, input logic [15:0] m);
		if (v == 16'h0000) begin
			return 16'hFFFF;
		end
		if (v == m && m > 16'h0000 && m < 16'h7FFF) begin
			return m + 16'h0001;
		end
		return v;
	endfunction
endmodule

// [testbench/tpwm_bench.sv]
// self-checking bench for the timer pwm unit
`timescale 1ns/1ps
module tpwm_bench import tpwm_pkg::*;;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [31:0] e;
		logic [1:0] r;
	} tpwm_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	tpwm_axi_req_t axi_req;
	tpwm_axi_rsp_t axi_rsp;
	logic [1:0] pwm_out;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int h;
	int h1;
	logic [31:0] v;
	logic [31:0] u;
	logic [1:0] rs;
	tpwm_row_t rows [7] = '{
		'{8'h08, 32'h1234, 4'hF, 32'h1234, 2'h0},
		'{8'h08, 32'hAB00, 4'h2, 32'hAB34, 2'h0},
		'{8'h10, 32'h5678, 4'h1, 32'h0078, 2'h0},
		'{8'h14, 32'hFFFF, 4'h3, 32'hFFFF, 2'h0},
		'{8'h04, 32'hFFFF, 4'h2, 32'h0000, 2'h0},
		'{8'h0C, 32'h0055, 4'hF, 32'h0000, TPWM_RESP_DECERR},
		'{8'h00, 32'h003C, 4'h1, 32'h003C, 2'h0}
	};
	always #4 aclk = ~aclk;
	tpwm_top u_tpwm_top (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .pwm_out(pwm_out));
	tpwm_sw_model u_tpwm_sw_model (.aclk(aclk), .axi_rsp(axi_rsp), .axi_req(axi_req));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("Error %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		u_tpwm_sw_model.wr(a, d, 4'hF, rs);
	endtask
	task automatic rd(input logic [7:0] a);
		u_tpwm_sw_model.rd(a, v, rs);
	endtask
	// settle for p clocks, then count active clocks over n
	task automatic run(input int p, input int n);
		repeat (p) @(posedge aclk);
		h = 0;
		h1 = 0;
		repeat (n) begin
			@(posedge aclk);
			h += pwm_out[0];
			h1 += pwm_out[1];
		end
	endtask
	// bounded poll until the count runs downward
	task automatic down();
		v = '0;
		repeat (60) begin
			if (v[16] !== 1'b1) begin
				rd(TPWM_COUNT_OFS);
			end
		end
	endtask
	// bounded poll until the count runs upward
	task automatic up();
		v = 32'h00010000;
		repeat (60) begin
			if (v[16] !== 1'b0) begin
				rd(TPWM_COUNT_OFS);
			end
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			u_tpwm_sw_model.wr(rows[i].a, rows[i].d, rows[i].s, rs);
			chk(32'(rs), 32'(rows[i].r));
			rd(rows[i].a);
			chk({rs, v[29:0]}, {rows[i].r, rows[i].e[29:0]});
		end
		// second reset in mid-run
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk({rs, v[29:0]}, {rows[i].r, 30'h0});
		end
		w(8'h08, 32'h8);
		w(8'h10, 32'h8);
		w(8'h14, 32'h8000);
		w(8'h00, 32'h21);
		run(48, 16);
		chk(h, 16);
		chk(h1, 0);
		w(8'h10, 32'h7);
		w(8'h14, {16'h0, u_tpwm_sw_model.duty_word(16'h0, 16'h8)});
		run(48, 16);
		chk(h, 14);
		chk(h1, 0);
		w(8'h10, {16'h0, u_tpwm_sw_model.duty_word(16'h8, 16'h8)});
		run(48, 16);
		chk(h, 16);
		// prescale is only touched while stopped
		w(8'h00, 32'h20);
		w(8'h00, 32'h24);
		w(8'h10, 32'h3);
		w(8'h00, 32'h25);
		run(96, 32);
		chk(h, 12);
		w(8'h00, 32'h20);
		w(8'h08, 32'h10);
		w(8'h10, 32'h6);
		w(8'h00, 32'h21);
		run(96, 32);
		chk(h, 12);
		down();
		w(8'h00, 32'h20);
		rd(TPWM_COUNT_OFS);
		u = v;
		run(5, 0);
		rd(TPWM_COUNT_OFS);
		chk(v, u);
		chk(32'(u[16]), 32'h1);
		w(TPWM_COUNT_OFS, 32'h0);
		rd(TPWM_COUNT_OFS);
		chk(v, 32'h0);
		w(8'h00, 32'h21);
		rd(TPWM_COUNT_OFS);
		chk(32'(v[16:4] == 13'h0 && v[3:0] != 4'h0), 32'h1);
		w(8'h10, 32'h0);
		run(40, 0);
		down();
		w(8'h10, 32'h4);
		run(0, 16);
		chk(h, 0);
		run(96, 32);
		chk(h, 8);
		w(8'h10, 32'h0);
		w(8'h08, 32'h8);
		w(8'h00, 32'h1);
		run(20, 0);
		w(8'h10, 32'h4);
		run(0, 9);
		chk(h, 0);
		run(18, 9);
		chk(h, 4);
		// center mode, value dropped to zero while counting up: old value finishes
		w(8'h08, 32'h10);
		w(8'h10, 32'hA);
		w(8'h00, 32'h21);
		run(72, 0);
		up();
		down();
		fork
			run(0, 96);
			begin
				up();
				w(8'h10, 32'h0);
			end
		join
		chk(h, 20);
		// zero, nonzero, zero across two periods
		up();
		down();
		w(8'h10, 32'h4);
		fork
			run(0, 96);
			begin
				up();
				down();
				w(8'h10, 32'h0);
			end
		join
		chk(h, 8);
		chk(h1, 0);
		report_and_stop();
	end
endmodule
